// ---- verilog/reset_sequencer_consts.svh ----
/*
 * Sequencer constants: offsets, fields, reset values, cycle counts.
 * Assumes inclusion by bare name.
 */
`ifndef RESET_SEQUENCER_CONSTS_SVH
`define RESET_SEQUENCER_CONSTS_SVH

// register offsets on the plain register port
`define OFS_INT_FLAGS_1    3'h0
`define OFS_INT_FLAGS_2    3'h1
`define OFS_INT_FLAGS_3    3'h2
`define OFS_INT_FLAGS_4    3'h3
`define OFS_RESET_CAUSE    3'h4

// reset cause register fields
`define CAUSE_LVD_BIT      1
`define CAUSE_MONITOR_BIT  2
`define CAUSE_ILLADDR_BIT  3
`define CAUSE_ILLOP_BIT    4
`define CAUSE_WATCHDOG_BIT 5
`define CAUSE_PIN_BIT      6
`define CAUSE_POWERON_BIT  7
`define CAUSE_RESET_VALUE  8'h80

// timing in oscillator clock cycles
`define SHORT_CYCLES       32
`define LONG_CYCLES        4096

// pending flags that read zero (flags 17 to 20, bit 0 is flag 1)
`define RESERVED_FLAGS     24'h0f0000
`define NO_REQUEST         5'h00

`endif

// ---- verilog/reset_sequencer_pkg.sv ----
/*
 * Types of the sequencer design files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package reset_sequencer_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        SEQ_RUN, SEQ_SUPPLY_WAIT, SEQ_LONG_HOLD, SEQ_PIN_LOW, SEQ_CPU_HOLD, SEQ_STOPPED, SEQ_RECOVER
    } seq_state_t;

    // option bits fixed at build time of the part
    typedef struct packed {
        logic watchdogDisable;
        logic stopEnable;
        logic lowVoltagePowerDown;
        logic lowVoltageResetDisable;
        logic shortRecovery;
    } option_t;

    // decoded cpu activity, one cycle pulses except interruptMask
    typedef struct packed {
        logic illegalOpcode;
        logic stopExecuted;
        logic opcodeFetch;
        logic fetchUnmapped;
        logic instructionDone;
        logic softwareInterrupt;
        logic interruptMask;
        logic vectorServiced;
    } cpu_event_t;

    // arbitration result handed to the cpu
    typedef struct packed {
        logic       valid;
        logic       software;
        logic [4:0] flagIndex;
        logic       stackDecrementedPc;
    } grant_t;

endpackage

// ---- verilog/stabilization_counter.sv ----
/*
 * Free running counter with synchronous clear and wrap pulse.
 * Assumes the oscillator clock.
 */
`timescale 1ns/1ps
module stabilization_counter #(
    parameter int WIDTH = 12
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // control
    input  wire logic             clear,
    // status
    output logic [WIDTH-1:0]      count,
    output logic                  overflow
);

    logic [WIDTH-1:0] count_q;

    // counts every cycle; clear wins so recovery timing starts from zero
    always_ff @(posedge clk) begin
        if (reset || clear) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + 1'b1;
        end
    end

    // wrap pulse from the register, one cycle long
    always_ff @(posedge clk) begin
        if (reset || clear) begin
            overflow <= 1'b0;
        end else begin
            overflow <= &count_q;
        end
    end

    assign count = count_q;

endmodule // stabilization_counter

// ---- verilog/interrupt_arbiter.sv ----
/*
 * Fixed priority latch: software first, then flag 1 to 24.
 * Assumes requests held as levels until serviced.
 */
`timescale 1ns/1ps
`include "reset_sequencer_consts.svh"
module interrupt_arbiter
    import reset_sequencer_pkg::*;
#(
    parameter int SOURCES = 24
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    // flush on internal reset
    input  wire logic               flush,
    // requests and enables, bit 0 is flag 1
    input  wire logic [SOURCES-1:0] requests,
    input  wire logic [SOURCES-1:0] enables,
    // cpu activity
    input  wire cpu_event_t         cpuEvent,
    // result
    output grant_t                  grant
);

    // lowest index wins; index 0 means none
    function automatic logic [4:0] first_set(input logic [SOURCES-1:0] v);
        logic [4:0] idx;
        idx = `NO_REQUEST;
        for (int i = SOURCES - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i + 1);
            end
        end
        return idx;
    endfunction

    logic [SOURCES-1:0] eligible;
    logic [4:0]         winner;

    // reserved positions never compete
    assign eligible = requests & enables & ~SOURCES'(`RESERVED_FLAGS);
    assign winner   = first_set(eligible);

    // latched until serviced, so a later higher request cannot take over
    always_ff @(posedge clk) begin
        if (reset || flush) begin
            grant <= '0;
        end else if (grant.valid) begin
            if (cpuEvent.vectorServiced) begin
                grant <= '0;
            end
        end else if (cpuEvent.instructionDone) begin
            if (cpuEvent.softwareInterrupt) begin
                grant <= '{valid: 1'b1, software: 1'b1, flagIndex: `NO_REQUEST,
                           stackDecrementedPc: 1'b0};
            end else if (!cpuEvent.interruptMask && winner != `NO_REQUEST) begin
                grant <= '{valid: 1'b1, software: 1'b0, flagIndex: winner,
                           stackDecrementedPc: 1'b1};
            end
        end
    end

endmodule // interrupt_arbiter

// ---- verilog/reset_and_interrupt_sequencer.sv ----
/*
 * Reset and interrupt sequencer: reset sources, cause flags, reset pin,
 * stabilization timing for power-on and stop recovery,
 * fixed priority interrupt latch and read-only flags.
 * Assumes inputs synchronous to clk (oscillator clock) and a cpu
 * that stacks and fetches the vector it is granted.
 */
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`include "reset_sequencer_consts.svh"
module reset_and_interrupt_sequencer
    import reset_sequencer_pkg::*;
#(
    parameter int COUNTER_WIDTH = 12,
    parameter int SOURCES       = 24,
    parameter int LONG_DELAY    = `LONG_CYCLES,
    parameter int SHORT_DELAY   = `SHORT_CYCLES
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    // register port
    input  wire logic [2:0]         regAddr,
    input  wire logic [7:0]         regWriteData,
    input  wire logic               regWrite,
    input  wire logic               regRead,
    output logic [7:0]              regReadData,
    // option bits
    input  wire option_t            options,
    // reset sources
    input  wire logic               powerOnReset,
    input  wire logic               watchdogOverflow,
    input  wire logic               lowVoltageDetect,
    input  wire logic               forcedMonitorEntry,
    // watchdog disable conditions
    input  wire logic               monitorMode,
    input  wire logic               breakState,
    input  wire logic               resetPinAtTestVoltage,
    input  wire logic               irqPinAtTestVoltage,
    // stop wakeup from interrupt or break
    input  wire logic               stopWake,
    // cpu side
    input  wire cpu_event_t         cpuEvent,
    input  wire logic [SOURCES-1:0] interruptRequests,
    input  wire logic [SOURCES-1:0] interruptEnables,
    output grant_t                  grant,
    output logic                    cpuResetHold,
    output logic                    busClockEnable,
    output logic                    clockGeneratorEnable,
    output logic                    stackIndexHigh,
    // watchdog side
    output logic                    watchdogEnable,
    output logic                    watchdogClockTick,
    // open drain reset pin
    output logic                    resetPinOut,
    output logic                    resetPinOe
);

    ////////////////////////////////////////////////////////////////////////////////////
    // declarations

    localparam logic [COUNTER_WIDTH-1:0] LongLast  = COUNTER_WIDTH'(LONG_DELAY - 1);
    localparam logic [COUNTER_WIDTH-1:0] ShortLast = COUNTER_WIDTH'(SHORT_DELAY - 1);

    seq_state_t               state_q;
    seq_state_t               state_d;
    logic [7:0]               cause_q;
    logic [7:0]               causeSet;
    logic [7:0]               regReadData_q;
    logic                     clockGeneratorEnable_q;
    logic [COUNTER_WIDTH-1:0] count;
    logic                     counterOverflow;
    logic                     counterClear;
    logic                     watchdogReset;
    logic                     illegalOpReset;
    logic                     illegalAddrReset;
    logic                     lowVoltageReset;
    logic                     shortReset;
    logic                     inResetState;
    logic [31:0]              flagWord;

    // register decode used by the clearing read of the reset cause register
    function automatic logic is_addr(input logic [2:0] a, input logic [2:0] ofs);
        return a == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////
    // reset source qualification

    // test voltage on pins switches the watchdog off for debugging
    assign watchdogEnable = !options.watchdogDisable
                          && !(monitorMode && (resetPinAtTestVoltage || irqPinAtTestVoltage))
                          && !(breakState && resetPinAtTestVoltage);

    assign watchdogReset    = watchdogOverflow && watchdogEnable;
    assign illegalOpReset   = cpuEvent.illegalOpcode
                            || (cpuEvent.stopExecuted && !options.stopEnable);
    // data accesses never qualify, only opcode fetches
    assign illegalAddrReset = cpuEvent.opcodeFetch && cpuEvent.fetchUnmapped;
    assign lowVoltageReset  = lowVoltageDetect && !options.lowVoltagePowerDown
                            && !options.lowVoltageResetDisable;

    // sources using the short pin pulse
    assign shortReset = watchdogReset || illegalOpReset || illegalAddrReset
                      || forcedMonitorEntry;

    assign inResetState = state_q == SEQ_SUPPLY_WAIT || state_q == SEQ_LONG_HOLD
                        || state_q == SEQ_PIN_LOW || state_q == SEQ_CPU_HOLD;

    ////////////////////////////////////////////////////////////////////////////////////
    // sequencer next state

    // power loss outranks everything; short sources start the pin pulse from run, stop, recovery or cpu hold
    always_comb begin
        state_d = state_q;
        if (powerOnReset || lowVoltageReset) begin
            state_d = SEQ_SUPPLY_WAIT;
        end else if (shortReset && state_q != SEQ_SUPPLY_WAIT && state_q != SEQ_LONG_HOLD) begin
            state_d = SEQ_PIN_LOW;
        end else begin
            case (state_q)
                SEQ_RUN: begin
                    if (cpuEvent.stopExecuted && options.stopEnable) begin
                        state_d = SEQ_STOPPED;
                    end
                end
                SEQ_SUPPLY_WAIT: begin
                    state_d = SEQ_LONG_HOLD;
                end
                SEQ_LONG_HOLD: begin
                    if (count == LongLast) begin
                        state_d = SEQ_PIN_LOW;
                    end
                end
                SEQ_PIN_LOW: begin
                    if (count == ShortLast) begin
                        state_d = SEQ_CPU_HOLD;
                    end
                end
                SEQ_CPU_HOLD: begin
                    if (count == ShortLast) begin
                        state_d = SEQ_RUN;
                    end
                end
                SEQ_STOPPED: begin
                    if (stopWake) begin
                        state_d = SEQ_RECOVER;
                    end
                end
                SEQ_RECOVER: begin
                    if (count == (options.shortRecovery ? ShortLast : LongLast)) begin
                        state_d = SEQ_RUN;
                    end
                end
                default: begin
                    state_d = SEQ_SUPPLY_WAIT;
                end
            endcase
        end
    end

    // state register; reset acts like a power-on so the long hold runs first
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= SEQ_SUPPLY_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // stabilization counter

    // cleared on phase change so each phase counts from zero;
    // held while stopped or supply low
    assign counterClear = state_d != state_q
                        || state_q == SEQ_STOPPED
                        || lowVoltageReset;

    stabilization_counter #(
        .WIDTH    (COUNTER_WIDTH)
    ) u_counter (
        .clk      (clk),
        .reset    (reset),
        .clear    (counterClear),
        .count    (count),
        .overflow (counterOverflow)
    );

    // wrap of the counter is the watchdog prescaler output
    assign watchdogClockTick = counterOverflow;

    ////////////////////////////////////////////////////////////////////////////////////
    // reset cause register

    always_comb begin
        causeSet                      = 8'h00;
        causeSet[`CAUSE_WATCHDOG_BIT] = watchdogReset;
        causeSet[`CAUSE_ILLOP_BIT]    = illegalOpReset;
        causeSet[`CAUSE_ILLADDR_BIT]  = illegalAddrReset;
        causeSet[`CAUSE_MONITOR_BIT]  = forcedMonitorEntry;
        causeSet[`CAUSE_LVD_BIT]      = lowVoltageReset;
    end

    // a new cause in the cycle of the clearing read survives the read
    always_ff @(posedge clk) begin
        if (reset || powerOnReset) begin
            cause_q <= `CAUSE_RESET_VALUE;
        end else if (regRead && is_addr(regAddr, `OFS_RESET_CAUSE)) begin
            cause_q <= causeSet;
        end else begin
            cause_q <= cause_q | causeSet;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // register read path

    // pending flags mirror the request lines; unused bits and reserved flags read zero
    assign flagWord = {6'h00, interruptRequests & ~SOURCES'(`RESERVED_FLAGS), 2'h0};

    // read data stand in the cycle after the strobe only; writes change nothing
    always_ff @(posedge clk) begin
        if (reset || !regRead) begin
            regReadData_q <= 8'h00;
        end else begin
            case (regAddr)
                `OFS_INT_FLAGS_1: regReadData_q <= flagWord[7:0];
                `OFS_INT_FLAGS_2: regReadData_q <= flagWord[15:8];
                `OFS_INT_FLAGS_3: regReadData_q <= flagWord[23:16];
                `OFS_INT_FLAGS_4: regReadData_q <= flagWord[31:24];
                `OFS_RESET_CAUSE: regReadData_q <= cause_q;
                default:          regReadData_q <= 8'h00;
            endcase
        end
    end

    assign regReadData = regReadData_q;  // regWrite and regWriteData unused

    ////////////////////////////////////////////////////////////////////////////////////
    // interrupt latch

    // flushed by every internal reset so no stale vector survives it
    interrupt_arbiter #(
        .SOURCES   (SOURCES)
    ) u_arbiter (
        .clk       (clk),
        .reset     (reset),
        .flush     (inResetState),
        .requests  (interruptRequests),
        .enables   (interruptEnables),
        .cpuEvent  (cpuEvent),
        .grant     (grant)
    );

    // index high register is never part of the hardware stack frame
    assign stackIndexHigh = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////////
    // clock and pin outputs

    // clock generator comes up once the sequencer has left its own reset
    always_ff @(posedge clk) begin
        if (reset) begin
            clockGeneratorEnable_q <= 1'b0;
        end else begin
            clockGeneratorEnable_q <= 1'b1;
        end
    end

    assign clockGeneratorEnable = clockGeneratorEnable_q;

    // pin pulled low through the long hold and the short pulse; never driven high
    assign resetPinOut    = 1'b0;
    assign resetPinOe     = state_q == SEQ_SUPPLY_WAIT || state_q == SEQ_LONG_HOLD
                          || state_q == SEQ_PIN_LOW;
    assign cpuResetHold   = inResetState;
    // cpu stacking and masking happen only while bus clocks run
    assign busClockEnable = state_q == SEQ_RUN;

endmodule // reset_and_interrupt_sequencer

// ---- dv/seq_checker.sv ----
/* port checker of the sequencer
   assumes one clock and a bind onto its top */
`timescale 1ns/1ps
module seq_checker
    import reset_sequencer_pkg::*;
#(
    parameter int LONG_DELAY = 4096
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // levels and events
    input wire option_t    options,
    input wire logic       monitorMode,
    input wire logic       breakState,
    input wire logic       resetPinAtTestVoltage,
    input wire logic       irqPinAtTestVoltage,
    input wire logic       stopWake,
    input wire cpu_event_t cpuEvent,
    // results
    input wire grant_t     grant,
    input wire logic       cpuResetHold,
    input wire logic       busClockEnable,
    input wire logic       stackIndexHigh,
    input wire logic       watchdogEnable,
    input wire logic       watchdogClockTick,
    input wire logic       resetPinOe
);
    logic [12:0] pinLen;
    logic [11:0] gap;
    logic        gapOk;
    // pin low length; tick spacing, trusted after a tick in run
    always_ff @(posedge clk) begin
        pinLen <= (reset || !resetPinOe) ? 13'h0000 : pinLen + 13'h0001;
        gap    <= watchdogClockTick ? 12'h000 : gap + 12'h001;
        gapOk  <= !reset && busClockEnable && (gapOk || watchdogClockTick);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    property p_pinLow; busClockEnable && cpuEvent.illegalOpcode |=> resetPinOe && cpuResetHold; endproperty
    a_pinLow: assert property (p_pinLow) else $error("no reset after illegal opcode");
    property p_stopIll; busClockEnable && cpuEvent.stopExecuted && !options.stopEnable |=> resetPinOe; endproperty
    a_stopIll: assert property (p_stopIll) else $error("disabled stop did not reset");
    property p_wdGate;
        monitorMode && (resetPinAtTestVoltage || irqPinAtTestVoltage) || breakState && resetPinAtTestVoltage
            |-> !watchdogEnable;
    endproperty
    a_wdGate: assert property (p_wdGate) else $error("watchdog enabled at test voltage");
    property p_cpuHold; $fell(resetPinOe) |-> cpuResetHold ##31 cpuResetHold ##1 !cpuResetHold && busClockEnable; endproperty
    a_cpuHold: assert property (p_cpuHold) else $error("cpu hold not 32 cycles");
    property p_pinLen; $fell(resetPinOe) |-> pinLen == 32 || pinLen >= LONG_DELAY + 32 && pinLen <= LONG_DELAY + 34; endproperty
    a_pinLen: assert property (p_pinLen) else $error("reset pin low length wrong");
    property p_stop; busClockEnable && cpuEvent.stopExecuted && options.stopEnable |=> !busClockEnable && !resetPinOe; endproperty
    a_stop: assert property (p_stop) else $error("stop did not halt bus clocks");
    property p_wake; stopWake && options.shortRecovery && !busClockEnable && !cpuResetHold
        |-> ##30 !busClockEnable ##[1:4] busClockEnable; endproperty
    a_wake: assert property (p_wake) else $error("short stop recovery wrong");
    property p_mask; busClockEnable && cpuEvent.instructionDone && cpuEvent.interruptMask
        && !cpuEvent.softwareInterrupt && !grant.valid |=> !grant.valid; endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt taken");
    property p_swi; busClockEnable && cpuEvent.instructionDone && cpuEvent.softwareInterrupt && !grant.valid
        |=> grant.valid && grant.software && grant.flagIndex == 5'h00 && !grant.stackDecrementedPc; endproperty
    a_swi: assert property (p_swi) else $error("software interrupt grant wrong");
    property p_hold; grant.valid && !cpuEvent.vectorServiced |=> $stable(grant) || cpuResetHold; endproperty
    a_hold: assert property (p_hold) else $error("latched grant changed");
    property p_tick; watchdogClockTick && gapOk |-> gap == 12'hfff; endproperty
    a_tick: assert property (p_tick) else $error("watchdog tick spacing wrong");
    property p_noIndex; grant.valid |-> !stackIndexHigh; endproperty
    a_noIndex: assert property (p_noIndex) else $error("index high stacked");
endmodule // seq_checker
bind reset_and_interrupt_sequencer seq_checker #(.LONG_DELAY(LONG_DELAY)) chk (.clk, .reset, .options,
    .monitorMode, .breakState, .resetPinAtTestVoltage, .irqPinAtTestVoltage, .stopWake, .cpuEvent, .grant,
    .cpuResetHold, .busClockEnable, .stackIndexHigh, .watchdogEnable, .watchdogClockTick, .resetPinOe);

// ---- dv/cpu_core_model.sv ----
/* cpu core stand-in: retires instructions and takes granted vectors
   assumes a registered grant from the sequencer, one clock */
`timescale 1ns/1ps
module cpu_core_model
    import reset_sequencer_pkg::*;
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   reset,
    // control and grant
    input  wire logic   run,
    input  wire grant_t grant,
    // decoded activity
    output cpu_event_t  events
);
    logic [3:0] cnt;
    // free count varies service delay; latch must hold
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt    <= 4'h0;
            events <= '0;
        end else begin
            cnt                    <= cnt + 4'h1;
            events.vectorServiced  <= 1'b0;
            events.instructionDone <= run && cnt[1:0] == 2'h3;
            if (grant.valid && cnt == 4'h6) begin
                events.vectorServiced <= 1'b1;
                events.interruptMask  <= 1'b1;
                cnt                   <= 4'h0;
            end else if (cnt == 4'hf) begin
                events.interruptMask <= 1'b0; // return restores the mask
            end
        end
    end
endmodule // cpu_core_model

// ---- dv/testbench.sv ----
/* self-checking bench of the sequencer
   assumes package, checker and cpu model compiled first */
`timescale 1ns/1ps
module testbench
    import reset_sequencer_pkg::*;
;
    logic       clk, reset, regWrite, regRead, powerOnReset, watchdogOverflow, lowVoltageDetect;
    logic       forcedMonitorEntry, monitorMode, breakState, resetPinAtTestVoltage, irqPinAtTestVoltage;
    logic       stopWake, modelRun, cpuResetHold, busClockEnable, clockGeneratorEnable, stackIndexHigh;
    logic       watchdogEnable, watchdogClockTick, resetPinOut, resetPinOe;
    logic [2:0] regAddr;
    logic [7:0] regWriteData, regReadData;
    logic [23:0] interruptRequests, interruptEnables, pat;
    option_t    options;
    cpu_event_t tbEv, modelEv, cpuEvent;
    grant_t     grant;
    int         err_count, n_tests, n, e;
    logic [7:0] causeExp [13] = '{8'h20, 8'h00, 8'h00, 8'h20, 8'h00, 8'h10, 8'h10, 8'h08, 8'h00, 8'h04, 8'h02, 8'h00, 8'h00};
    int         order [4] = '{1, 3, 2, 24};
    assign cpuEvent = tbEv | modelEv;
    reset_and_interrupt_sequencer #(.LONG_DELAY(64)) dut (.clk, .reset, .regAddr, .regWriteData, .regWrite, .regRead,
        .regReadData, .options, .powerOnReset, .watchdogOverflow, .lowVoltageDetect, .forcedMonitorEntry, .monitorMode,
        .breakState, .resetPinAtTestVoltage, .irqPinAtTestVoltage, .stopWake, .cpuEvent, .interruptRequests,
        .interruptEnables, .grant, .cpuResetHold, .busClockEnable, .clockGeneratorEnable, .stackIndexHigh,
        .watchdogEnable, .watchdogClockTick, .resetPinOut, .resetPinOe);
    cpu_core_model model (.clk, .reset, .run(busClockEnable && modelRun), .grant, .events(modelEv));
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(regReadData, exp);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr      <= a;
        regWriteData <= d;
        regWrite     <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // bounded wait on bus clocks (sel 0) or grant (sel 1)
    task automatic waitv(input int sel, input logic v, output int cnt);
        cnt = 0;
        while ((sel ? grant.valid : busClockEnable) !== v && cnt < 300) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= 300) begin
            err_count++;
            end_of_test();
        end
    endtask
    // one reset source pulse
    task automatic fire(input int k);
        @(posedge clk);
        watchdogOverflow      <= k < 5;
        monitorMode           <= k == 2;
        irqPinAtTestVoltage   <= k == 2 || k == 3;
        breakState            <= k == 3 || k == 4;
        resetPinAtTestVoltage <= k == 4;
        options               <= {k == 1, k != 6, k == 12, k == 11, 1'b0};
        tbEv                  <= {k == 5, k == 6, k == 7, k == 7 || k == 8, 4'h0};
        forcedMonitorEntry    <= k == 9;
        lowVoltageDetect      <= k >= 10 && k < 13;
        powerOnReset          <= k == 13;
        @(posedge clk);
        {watchdogOverflow, monitorMode, irqPinAtTestVoltage, breakState, resetPinAtTestVoltage} <= 5'h00;
        {forcedMonitorEntry, lowVoltageDetect, powerOnReset} <= 3'h0;
        options <= 5'h08;
        tbEv    <= '0;
        @(negedge clk);
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {reset, regWrite, regRead, regAddr, regWriteData} = 14'h2000;
        {powerOnReset, watchdogOverflow, lowVoltageDetect, forcedMonitorEntry, monitorMode} = 5'h00;
        {breakState, resetPinAtTestVoltage, irqPinAtTestVoltage, stopWake, modelRun} = 5'h01;
        {options, tbEv, interruptRequests, interruptEnables} = {5'h08, 8'h00, 24'h000000, ~24'h000020};
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        waitv(0, 1'b1, n);
        chk(clockGeneratorEnable, 8'h01);
        rd(3'h4, 8'h80);
        rd(3'h4, 8'h00);
        for (int k = 0; k < 13; k++) begin
            fire(k);
            chk(resetPinOe, causeExp[k] != 8'h00);
            waitv(0, 1'b1, n);
            rd(3'h4, causeExp[k]);
        end
        fire(9);
        waitv(0, 1'b1, n);
        fire(13);
        waitv(0, 1'b1, n);
        rd(3'h4, 8'h80);
        modelRun <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            pat = i ? 24'h5a3c81 : 24'hffffff;
            interruptRequests <= pat;
            for (int j = 0; j < 4; j++) wr(j[2:0], 8'h00);
            rd(3'h0, {pat[5:0], 2'b00});
            rd(3'h1, pat[13:6]);
            rd(3'h2, {pat[21:20], 4'h0, pat[15:14]});
            rd(3'h3, {6'h00, pat[23:22]});
        end
        rd(3'h5, 8'h00); // unmapped
        interruptRequests <= 24'h810025;
        @(posedge clk);
        tbEv <= 8'h0c;
        @(posedge clk);
        tbEv     <= '0;
        modelRun <= 1'b1;
        @(negedge clk);
        chk(grant, 8'hc0);
        foreach (order[i]) begin
            waitv(1, 1'b0, n);
            waitv(1, 1'b1, n);
            chk(grant, {2'h2, order[i][4:0], 1'b1});
            @(posedge clk);
            interruptRequests[order[i] - 1] <= 1'b0;
            if (order[i] == 3) interruptRequests[1] <= 1'b1;
        end
        waitv(1, 1'b0, n);
        e = 0;
        repeat (60) @(negedge clk) e += grant.valid;
        chk(e[7:0], 8'h00);
        for (int i = 0; i < 2; i++) begin
            options.shortRecovery <= i[0];
            @(posedge clk);
            tbEv <= 8'h40;
            @(posedge clk);
            tbEv <= '0;
            repeat (10) @(posedge clk);
            stopWake <= 1'b1;
            @(posedge clk);
            stopWake <= 1'b0;
            waitv(0, 1'b1, n);
            e = i ? 32 : 64;
            chk(n >= e - 1 && n <= e + 2, 8'h01);
        end
        repeat (9000) @(posedge clk);
        end_of_test();
    end
endmodule // testbench
